/* File: design/xdo_pkg.sv */
package xdo_pkg;

  // ----------------------------------------------------------------
  // Register map (word offsets as byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] XDO_OFF_CMD     = 4'h0; // Write: launch op
  localparam logic [3:0] XDO_OFF_WORK    = 4'h4; // Working register
  localparam logic [3:0] XDO_OFF_STATUS  = 4'h8; // Flags
  localparam logic [3:0] XDO_OFF_DIR_A   = 4'hc;

  // Second page of the map
  localparam logic [4:0] XDO_OFF_DIR_B   = 5'h10;
  localparam logic [4:0] XDO_OFF_DIR_C   = 5'h14;
  localparam logic [4:0] XDO_OFF_MEMWIN  = 5'h18; // Data memory window

  // ----------------------------------------------------------------
  // Command word fields
  // ----------------------------------------------------------------
  localparam int XDO_CMD_OP_LSB   = 16; // [17:16] opcode
  localparam int XDO_CMD_DEST_BIT = 15; // Destination bit
  localparam int XDO_CMD_OPND_LSB = 0;  // [7:0] literal or address

  // Status flag positions
  localparam int XDO_ST_CARRY = 0;
  localparam int XDO_ST_DC    = 1;
  localparam int XDO_ST_ZERO  = 2;

  // Reset values
  localparam logic [7:0] XDO_RST_WORK = 8'h00;
  localparam logic [7:0] XDO_RST_DIR  = 8'hff; // All inputs
  localparam logic [2:0] XDO_RST_STAT = 3'h0;

  // Direction operand values
  localparam logic [2:0] XDO_DIR_SEL_A = 3'h5;
  localparam logic [2:0] XDO_DIR_SEL_B = 3'h6;
  localparam logic [2:0] XDO_DIR_SEL_C = 3'h7;

  // Operations
  typedef enum logic [1:0] {
    XDO_OP_NONE = 2'b00,
    XDO_OP_XOR_LITERAL = 2'b01,
    XDO_OP_XOR_REGISTER = 2'b10,
    XDO_OP_LOAD_DIRECTION = 2'b11
  } xdo_op_e;

endpackage

/* File: design/xdo_core.sv */
`timescale 1ns/1ps
module xdo_core
  import xdo_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 7
)(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  // Avalon-MM slave
  input  wire logic [4:0]        avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  // Direction registers to pads
  output logic      [DATA_W-1:0] port_a_direction_o,
  output logic      [DATA_W-1:0] port_b_direction_o,
  output logic      [DATA_W-1:0] port_c_direction_o
);

  // Only an 8-bit datapath over a 128-byte memory is supported
  if (DATA_W != 8 || ADDR_W != 7)
  begin : g_bad_size
    $error("xdo_core: only DATA_W 8 and ADDR_W 7 supported");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] work, next_work;
  logic [2:0]        status, next_status;
  logic [DATA_W-1:0] port_a_direction, next_port_a_direction;
  logic [DATA_W-1:0] port_b_direction, next_port_b_direction;
  logic [DATA_W-1:0] port_c_direction, next_port_c_direction;
  logic [31:0]       next_readdata;
  logic              ack, next_ack;
  logic              next_waitrequest;
  logic              mem_we;
  logic [ADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] mem_wdata;
  logic [DATA_W-1:0] mem_rdata;
  logic [DATA_W-1:0] result;
  xdo_op_e           op;
  logic              dest;
  logic [DATA_W-1:0] opnd;
  logic              req;

  // Decoded command fields
  assign op   = xdo_op_e'(avs_writedata_i[XDO_CMD_OP_LSB +: 2]);
  assign dest = avs_writedata_i[XDO_CMD_DEST_BIT];
  assign opnd = avs_writedata_i[XDO_CMD_OPND_LSB +: DATA_W];
  assign req  = (avs_read_i | avs_write_i) & ~ack;

  // Zero test shared by both xor forms
  function automatic logic is_zero(input logic [7:0] v);
    return (v == 8'h00);
  endfunction

  // Memory read is combinational; one-port array stays small
  assign mem_rdata = mem[mem_addr];

  // ----------------------------------------------------------------
  // Next-state: bus decode and execution
  // ----------------------------------------------------------------
  // Every access takes exactly one wait cycle, which keeps the
  // readdata flop-driven at the cost of one cycle of latency.
  always_comb
  begin
    next_work             = work;
    next_status           = status;
    next_port_a_direction = port_a_direction;
    next_port_b_direction = port_b_direction;
    next_port_c_direction = port_c_direction;
    next_readdata         = 32'h0000_0000;
    next_ack              = req;
    next_waitrequest      = ~req;
    mem_we                = 1'b0;
    mem_addr              = opnd[ADDR_W-1:0];
    mem_wdata             = 8'h00;
    result                = 8'h00;
    if (req && avs_write_i)
    begin
      if (avs_address_i == 5'(XDO_OFF_CMD))
      begin
        case (op)
          XDO_OP_XOR_LITERAL:
          begin
            result    = work ^ opnd;
            next_work = result;
            next_status[XDO_ST_ZERO] = is_zero(result);
          end
          XDO_OP_XOR_REGISTER:
          begin
            result = work ^ mem_rdata;
            next_status[XDO_ST_ZERO] = is_zero(result);
            if (dest)
            begin
              mem_we    = 1'b1;
              mem_wdata = result;
            end
            else
              next_work = result;
          end
          XDO_OP_LOAD_DIRECTION:
          begin
            // Operands outside 5..7 are ignored, flags untouched
            if (opnd == 8'(XDO_DIR_SEL_A))
              next_port_a_direction = work;
            else if (opnd == 8'(XDO_DIR_SEL_B))
              next_port_b_direction = work;
            else if (opnd == 8'(XDO_DIR_SEL_C))
              next_port_c_direction = work;
          end
          default:
          begin
            result = 8'h00;
          end
        endcase
      end
      else if (avs_address_i == 5'(XDO_OFF_WORK))
        next_work = opnd;
      else if (avs_address_i == XDO_OFF_MEMWIN)
      begin
        mem_addr  = avs_writedata_i[8 +: ADDR_W];
        mem_we    = 1'b1;
        mem_wdata = opnd;
      end
    end
    else if (req && avs_read_i)
    begin
      mem_addr = avs_writedata_i[8 +: ADDR_W];
      if (avs_address_i == 5'(XDO_OFF_WORK))
        next_readdata = {24'h000000, work};
      else if (avs_address_i == 5'(XDO_OFF_STATUS))
        next_readdata = {29'h0000000, status};
      else if (avs_address_i == 5'(XDO_OFF_DIR_A))
        next_readdata = {24'h000000, port_a_direction};
      else if (avs_address_i == XDO_OFF_DIR_B)
        next_readdata = {24'h000000, port_b_direction};
      else if (avs_address_i == XDO_OFF_DIR_C)
        next_readdata = {24'h000000, port_c_direction};
      else
        next_readdata = 32'h0000_0000; // Unmapped reads zero
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Control state and bus answer
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      work               <= XDO_RST_WORK;
      status             <= XDO_RST_STAT;
      port_a_direction   <= XDO_RST_DIR;
      port_b_direction   <= XDO_RST_DIR;
      port_c_direction   <= XDO_RST_DIR;
      avs_readdata_o     <= 32'h0000_0000;
      avs_waitrequest_o  <= 1'b1;
      ack                <= 1'b0;
    end
    else
    begin
      work               <= next_work;
      status             <= next_status;
      port_a_direction   <= next_port_a_direction;
      port_b_direction   <= next_port_b_direction;
      port_c_direction   <= next_port_c_direction;
      avs_readdata_o     <= next_readdata;
      avs_waitrequest_o  <= next_waitrequest;
      ack                <= next_ack;
    end
  end

  // Data memory has no reset, as a real RAM would not
  always_ff @(posedge clk_i)
  begin
    if (mem_we)
      mem[mem_addr] <= mem_wdata;
  end

  // Pins mirror the direction flops; waitrequest has its own flop
  assign port_a_direction_o = port_a_direction;
  assign port_b_direction_o = port_b_direction;
  assign port_c_direction_o = port_c_direction;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  logic cmd_w;
  assign cmd_w = req && avs_write_i && avs_address_i == 5'(XDO_OFF_CMD);

  property p_lit;
    logic [7:0] w;
    (cmd_w && op == XDO_OP_XOR_LITERAL, w = work ^ opnd) |=> work == w;
  endproperty
  a_lit: assert property (p_lit) else $error("literal xor wrong");

  property p_dir_a;
    logic [7:0] w;
    (cmd_w && op == XDO_OP_LOAD_DIRECTION && opnd == 8'h05, w = work)
      |=> port_a_direction_o == w;
  endproperty
  a_dir_a: assert property (p_dir_a) else $error("dir A not loaded");

  property p_dir_flags;
    cmd_w && op == XDO_OP_LOAD_DIRECTION |=> $stable(status);
  endproperty
  a_dir_flags: assert property (p_dir_flags) else $error("dir flags");

  property p_dir_bad;
    cmd_w && op == XDO_OP_LOAD_DIRECTION
      && (opnd < 8'h05 || opnd > 8'h07)
      |=> $stable(port_a_direction) && $stable(port_b_direction)
          && $stable(port_c_direction);
  endproperty
  a_dir_bad: assert property (p_dir_bad) else $error("bad dir op");

  property p_reg_w;
    logic [7:0] w;
    (cmd_w && op == XDO_OP_XOR_REGISTER && !dest, w = work ^ mem_rdata)
      |=> work == w;
  endproperty
  a_reg_w: assert property (p_reg_w) else $error("xor to W wrong");

  property p_reg_f;
    cmd_w && op == XDO_OP_XOR_REGISTER && dest |=> $stable(work);
  endproperty
  a_reg_f: assert property (p_reg_f) else $error("W changed, d=1");

  property p_zero;
    logic [7:0] r;
    (cmd_w && op == XDO_OP_XOR_REGISTER, r = work ^ mem_rdata)
      |=> status[XDO_ST_ZERO] == (r == 8'h00)
          && status[1:0] == $past(status[1:0]);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_wait;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_wait: assert property (p_wait) else $error("waitrequest stuck");

  c_lit: cover property (cmd_w && op == XDO_OP_XOR_LITERAL);
  c_regf: cover property (cmd_w && op == XDO_OP_XOR_REGISTER && dest);
  c_dirc: cover property (cmd_w && op == XDO_OP_LOAD_DIRECTION
                          && opnd == 8'h07);

endmodule // xdo_core

/* File: sim/test_xor_and_port_direction_ops.sv */
`timescale 1ns/1ps
module test_xor_and_port_direction_ops;
  import xdo_pkg::*;

  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic        clk_i;
  logic        reset_i;
  logic [4:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [7:0]  port_a_direction_o;
  logic [7:0]  port_b_direction_o;
  logic [7:0]  port_c_direction_o;
  int          failures;
  int          cmp_count;

  localparam logic [4:0] A_CMD  = {1'b0, XDO_OFF_CMD};
  localparam logic [4:0] A_WORK = {1'b0, XDO_OFF_WORK};
  localparam logic [4:0] A_STAT = {1'b0, XDO_OFF_STATUS};

  // Design under test
  xdo_core DUT (
    .clk_i              (clk_i),
    .reset_i            (reset_i),
    .avs_address_i      (avs_address_i),
    .avs_read_i         (avs_read_i),
    .avs_write_i        (avs_write_i),
    .avs_writedata_i    (avs_writedata_i),
    .avs_readdata_o     (avs_readdata_o),
    .avs_waitrequest_o  (avs_waitrequest_o),
    .port_a_direction_o (port_a_direction_o),
    .port_b_direction_o (port_b_direction_o),
    .port_c_direction_o (port_c_direction_o)
  );

  // 40 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // --------------------------------------------------------------
  // Bus and checking tasks
  // --------------------------------------------------------------
  task automatic results();
    $display("Compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Bounded wait: a stuck slave ends the run instead of hanging it
  task automatic wait_ack();
    int n;
    for (n = 0; n < 16; n++)
    begin
      @(posedge clk_i);
      if (avs_waitrequest_o === 1'b0)
        break;
    end
    if (n == 16)
    begin
      failures++;
      $display("[ERR] waitrequest expected 0 seen 1");
      results();
    end
  endtask

  // Extra edge after release so the next request never overlaps it
  task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= 1'b1;
    wait_ack();
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd_chk(input string name, input logic [4:0] a,
                        input logic [31:0] exp);
    logic [31:0] d;
    avs_address_i <= a;
    avs_read_i    <= 1'b1;
    wait_ack();
    d = avs_readdata_o;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
    check(name, d, exp);
  endtask

  function automatic logic [31:0] cmd(xdo_op_e op, logic dest,
                                      logic [7:0] opnd);
    return {14'h0, op, dest, 7'h0, opnd};
  endfunction

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_literal();
    bus_wr(A_WORK, 32'h5a);
    bus_wr(A_CMD, cmd(XDO_OP_XOR_LITERAL, 1'b0, 8'hff));
    rd_chk("work", A_WORK, 32'ha5);
    rd_chk("status", A_STAT, 32'h0);
    bus_wr(A_CMD, cmd(XDO_OP_XOR_LITERAL, 1'b0, 8'ha5));
    rd_chk("work", A_WORK, 32'h0);
    rd_chk("status", A_STAT, 32'h4);
  endtask

  task automatic t_register();
    bus_wr({1'b0, XDO_OFF_MEMWIN}, {17'h0, 7'h7f, 8'h3c});
    bus_wr({1'b0, XDO_OFF_MEMWIN}, {17'h0, 7'h00, 8'hc3});
    bus_wr(A_WORK, 32'h0f);
    bus_wr(A_CMD, cmd(XDO_OP_XOR_REGISTER, 1'b0, 8'h7f));
    rd_chk("work", A_WORK, 32'h33);
    rd_chk("status", A_STAT, 32'h0);
    bus_wr(A_WORK, 32'h00);
    bus_wr(A_CMD, cmd(XDO_OP_XOR_REGISTER, 1'b0, 8'h7f));
    rd_chk("work", A_WORK, 32'h3c);
    bus_wr(A_CMD, cmd(XDO_OP_XOR_REGISTER, 1'b1, 8'h7f));
    rd_chk("work", A_WORK, 32'h3c);
    rd_chk("status", A_STAT, 32'h4);
    bus_wr(A_WORK, 32'h00);
    bus_wr(A_CMD, cmd(XDO_OP_XOR_REGISTER, 1'b0, 8'h7f));
    rd_chk("work", A_WORK, 32'h0);
    bus_wr(A_CMD, cmd(XDO_OP_XOR_REGISTER, 1'b0, 8'h00));
    rd_chk("work", A_WORK, 32'hc3);
  endtask

  // Zero flag is set first so a stray flag update is visible
  task automatic t_direction();
    logic [4:0] offs[3];
    logic [7:0] outv;
    offs = '{{1'b0, XDO_OFF_DIR_A}, XDO_OFF_DIR_B, XDO_OFF_DIR_C};
    bus_wr(A_CMD, cmd(XDO_OP_XOR_LITERAL, 1'b0, 8'hc3));
    for (int i = 0; i < 3; i++)
    begin
      bus_wr(A_WORK, 32'h21 + i);
      bus_wr(A_CMD, cmd(XDO_OP_LOAD_DIRECTION, 1'b0, 8'(8'h05 + i)));
      outv = (i == 0) ? port_a_direction_o :
             (i == 1) ? port_b_direction_o : port_c_direction_o;
      check("direction pin", {24'h0, outv}, 32'h21 + i);
      rd_chk("direction", offs[i], 32'h21 + i);
      rd_chk("status", A_STAT, 32'h4);
    end
    bus_wr(A_WORK, 32'h99);
    bus_wr(A_CMD, cmd(XDO_OP_LOAD_DIRECTION, 1'b0, 8'h04));
    bus_wr(A_CMD, cmd(XDO_OP_LOAD_DIRECTION, 1'b0, 8'h00));
    bus_wr(A_CMD, cmd(XDO_OP_LOAD_DIRECTION, 1'b0, 8'h08));
    bus_wr(A_CMD, cmd(XDO_OP_NONE, 1'b0, 8'h05));
    for (int i = 0; i < 3; i++)
      rd_chk("direction kept", offs[i], 32'h21 + i);
    rd_chk("work", A_WORK, 32'h99);
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    failures        = 0;
    cmp_count       = 0;
    reset_i         = 1'b1;
    avs_address_i   = 5'h00;
    avs_read_i      = 1'b0;
    avs_write_i     = 1'b0;
    avs_writedata_i = 32'h0;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    check("pin a reset", {24'h0, port_a_direction_o}, 32'hff);
    rd_chk("work reset", A_WORK, 32'h0);
    rd_chk("unmapped", 5'h1c, 32'h0);
    t_literal();
    t_register();
    t_direction();
    results();
  end

endmodule // test_xor_and_port_direction_ops
